// >>> logic/frt_timer.sv
/*
 * Free-running 16-bit timer with one input capture and one output compare,
 * reached through a byte-wide CPU register port.
 * Assumes rd and wr are one-cycle strobes on clk, never together, and that
 * osc_ready rises once the oscillator start-up delay has ended.
 */
`timescale 1ns/1ps
// Behaviour
// - 16-bit counter runs freely, advancing once every four bus clocks.
// - Counter advances on its own tick; reads never change the count.
// - High-byte counter read buffers low byte; buffer frozen until low read.
// - Low-byte read without prior high read returns the live count.
// - Two addresses show the count; only the primary takes part in clearing.
// - Reset loads FFFC; counting waits for the oscillator start-up delay.
// - Wrap from FFFF to 0000 sets overflow flag, interrupting if enabled.
// - Compare value fully read/write, untouched by reset and hardware.
// - Equality sets compare flag, latches output level, interrupts if enabled.
// - Compare high write suspends matching until low write; low alone doesn't.
// - Writing one compare byte leaves the other unchanged.
// - Level latched on every match; pin driven after a match if output.
// - Selected edge on capture pin copies the counter into capture register.
// - Captured value is one plus the count before the transition.
// - Every qualifying edge not blocked by a capture high read captures, regardless of capture flag.
// - Capture high read blocks captures until capture low read.
// - Reset leaves capture register unchanged.
// - Flag clears after flags access while set, then its low-byte access.
// - Edge select 1 rising, 0 falling; unaffected by reset.
module frt_timer (
    input  wire logic                 clk,           // System clock, 200 MHz
    input  wire logic                 rst,           // Async reset, high
    input  wire logic                 osc_ready,     // Start-up delay ended
    input  wire frt_pkg::frt_bus_req_t bus_req,      // CPU byte access
    output logic [7:0]                rdata,         // Read data, registered
    input  wire logic                 capture_input_pin, // Capture pin
    input  wire logic                 compare_pin_direction_bit, // 1 drives pin
    output logic                      compare_output_pin, // Compare level
    output logic                      compare_output_en_n, // Low while pin driven
    output logic                      timer_irq      // Combined request
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [15:0]       count_q, count_d;
    logic [15:0]       count_p1_q, count_p2_q;
    logic [15:0]       capture_q, capture_d;
    logic [15:0]       compare_q, compare_d;
    logic [7:0]        lo_buf_q, lo_buf_d;
    logic              lo_held_q, lo_held_d;
    frt_pkg::frt_hold_t hold_q, hold_d;
    logic              cmp_inhibit_q, cmp_inhibit_d;
    logic              cap_block_q, cap_block_d;
    logic              ovf_flag_q, ovf_flag_d;
    logic              cmp_flag_q, cmp_flag_d;
    logic              cap_flag_q, cap_flag_d;
    logic              ovf_arm_q, ovf_arm_d;
    logic              cmp_arm_q, cmp_arm_d;
    logic              cap_arm_q, cap_arm_d;
    logic              level_q, level_d;
    logic              matched_q, matched_d;
    logic              cmp_check_q;
    logic [7:0]        rdata_q, rdata_d;
    frt_pkg::frt_ctrl_t ctrl_q, ctrl_d;
    logic              edge_q, edge_d;

    logic tick;
    logic cap_edge;
    logic rd_any;
    logic wr_any;
    logic flags_acc;
    logic match;
    logic pin_drive;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
        return a == target;
    endfunction

    // ------------------------------------------------------------
    // Prescaler and capture pin
    // ------------------------------------------------------------
    frt_prescale #(
        .DIV (frt_pkg::PRESCALE)
    ) u_prescale (
        .clk  (clk),
        .rst  (rst),
        .run  (osc_ready),
        .tick (tick)
    );

    frt_edge_sync u_edge (
        .clk       (clk),
        .rst       (rst),
        .pin       (capture_input_pin),
        .rise_sel  (edge_q),
        .edge_seen (cap_edge)
    );

    assign rd_any    = bus_req.rd;
    assign wr_any    = bus_req.wr;
    assign flags_acc = (rd_any || wr_any) && hit(bus_req.addr, frt_pkg::ADDR_FLAGS);
    // One check per count value, taken the cycle after the counter moves
    assign match     = cmp_check_q && !cmp_inhibit_q && (count_q == compare_q);

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    always_comb begin
        count_d = count_q;
        if (tick) begin
            count_d = count_q + 16'h0001;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count_q     <= frt_pkg::CNT_RESET;
            count_p1_q  <= frt_pkg::CNT_RESET;
            count_p2_q  <= frt_pkg::CNT_RESET;
            cmp_check_q <= 1'b0;
        end else begin
            count_q     <= count_d;
            count_p1_q  <= count_q;
            count_p2_q  <= count_p1_q;
            cmp_check_q <= tick;
        end
    end

    // ------------------------------------------------------------
    // Register access side effects and flags
    // ------------------------------------------------------------
    always_comb begin
        lo_buf_d      = lo_buf_q;
        lo_held_d     = lo_held_q;
        hold_d        = hold_q;
        cmp_inhibit_d = cmp_inhibit_q;
        cap_block_d   = cap_block_q;
        ovf_arm_d     = ovf_arm_q;
        cmp_arm_d     = cmp_arm_q;
        cap_arm_d     = cap_arm_q;
        ovf_flag_d    = ovf_flag_q;
        cmp_flag_d    = cmp_flag_q;
        cap_flag_d    = cap_flag_q;
        level_d       = level_q;
        matched_d     = matched_q;
        rdata_d       = rdata_q;

        if (flags_acc) begin
            ovf_arm_d = ovf_flag_q;
            cmp_arm_d = cmp_flag_q;
            cap_arm_d = cap_flag_q;
        end

        if (rd_any) begin
            case (bus_req.addr)
                frt_pkg::ADDR_CTRL: begin
                    rdata_d = {ctrl_q.cap_ie, ctrl_q.cmp_ie, ctrl_q.ovf_ie, 3'h0,
                               edge_q, ctrl_q.level};
                end
                frt_pkg::ADDR_FLAGS: begin
                    rdata_d = {cap_flag_q, cmp_flag_q, ovf_flag_q, 5'h00};
                end
                frt_pkg::ADDR_CAP_HI: begin
                    rdata_d     = capture_q[15:8];
                    cap_block_d = 1'b1;
                end
                frt_pkg::ADDR_CAP_LO: begin
                    rdata_d     = capture_q[7:0];
                    cap_block_d = 1'b0;
                    if (cap_arm_q) begin
                        cap_flag_d = 1'b0;
                        cap_arm_d  = 1'b0;
                    end
                end
                frt_pkg::ADDR_CMP_HI: rdata_d = compare_q[15:8];
                frt_pkg::ADDR_CMP_LO: begin
                    rdata_d = compare_q[7:0];
                    if (cmp_arm_q) begin
                        cmp_flag_d = 1'b0;
                        cmp_arm_d  = 1'b0;
                    end
                end
                frt_pkg::ADDR_CNT_HI, frt_pkg::ADDR_ALT_HI: begin
                    rdata_d = count_q[15:8];
                    if (!lo_held_q) begin
                        lo_buf_d  = count_q[7:0];
                        lo_held_d = 1'b1;
                    end
                end
                frt_pkg::ADDR_CNT_LO, frt_pkg::ADDR_ALT_LO: begin
                    rdata_d   = lo_held_q ? lo_buf_q : count_q[7:0];
                    lo_held_d = 1'b0;
                    if (hit(bus_req.addr, frt_pkg::ADDR_CNT_LO) && ovf_arm_q) begin
                        ovf_flag_d = 1'b0;
                        ovf_arm_d  = 1'b0;
                    end
                end
                default: rdata_d = 8'h00;
            endcase
        end

        if (wr_any) begin
            if (hit(bus_req.addr, frt_pkg::ADDR_CMP_HI)) begin
                cmp_inhibit_d = 1'b1;
            end
            if (hit(bus_req.addr, frt_pkg::ADDR_CMP_LO)) begin
                cmp_inhibit_d = 1'b0;
                if (cmp_arm_q) begin
                    cmp_flag_d = 1'b0;
                    cmp_arm_d  = 1'b0;
                end
            end
        end

        // Hardware events come last so a set wins over a same-cycle clear
        if (tick && (count_q == frt_pkg::CNT_MAX)) begin
            ovf_flag_d = 1'b1;
        end
        if (match) begin
            cmp_flag_d = 1'b1;
            level_d    = ctrl_q.level;
            matched_d  = 1'b1;
        end
        if (cap_edge && !cap_block_q) begin
            cap_flag_d = 1'b1;
        end
        hold_d = lo_held_d ? frt_pkg::RD_CNT : (cap_block_d ? frt_pkg::RD_CAP : frt_pkg::RD_IDLE);
    end

    // OVERFLOW_FLAG and control state take reset values
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lo_buf_q      <= 8'h00;
            lo_held_q     <= 1'b0;
            hold_q        <= frt_pkg::RD_IDLE;
            cmp_inhibit_q <= 1'b0;
            cap_block_q   <= 1'b0;
            ovf_arm_q     <= 1'b0;
            cmp_arm_q     <= 1'b0;
            cap_arm_q     <= 1'b0;
            ovf_flag_q    <= 1'b0;
            level_q       <= 1'b0;
            matched_q     <= 1'b0;
            rdata_q       <= 8'h00;
        end else begin
            lo_buf_q      <= lo_buf_d;
            lo_held_q     <= lo_held_d;
            hold_q        <= hold_d;
            cmp_inhibit_q <= cmp_inhibit_d;
            cap_block_q   <= cap_block_d;
            ovf_arm_q     <= ovf_arm_d;
            cmp_arm_q     <= cmp_arm_d;
            cap_arm_q     <= cap_arm_d;
            ovf_flag_q    <= ovf_flag_d;
            level_q       <= level_d;
            matched_q     <= matched_d;
            rdata_q       <= rdata_d;
        end
    end

    // Compare and capture flags survive reset, like the values they track
    always_ff @(posedge clk) begin
        cmp_flag_q <= cmp_flag_d;
        cap_flag_q <= cap_flag_d;
    end

    // ------------------------------------------------------------
    // Control, compare value, capture value
    // ------------------------------------------------------------
    always_comb begin
        ctrl_d    = ctrl_q;
        edge_d    = edge_q;
        compare_d = compare_q;
        capture_d = capture_q;
        if (wr_any) begin
            case (bus_req.addr)
                frt_pkg::ADDR_CTRL: begin
                    ctrl_d.cap_ie = bus_req.wdata[frt_pkg::CTRL_CAP_IE];
                    ctrl_d.cmp_ie = bus_req.wdata[frt_pkg::CTRL_CMP_IE];
                    ctrl_d.ovf_ie = bus_req.wdata[frt_pkg::CTRL_OVF_IE];
                    ctrl_d.level  = bus_req.wdata[frt_pkg::CTRL_LEVEL];
                    edge_d        = bus_req.wdata[frt_pkg::CTRL_EDGE];
                end
                frt_pkg::ADDR_CMP_HI: compare_d[15:8] = bus_req.wdata;
                frt_pkg::ADDR_CMP_LO: compare_d[7:0]  = bus_req.wdata;
                default: ;
            endcase
        end
        // Count lags the pin by the synchroniser; p2 lines up with the pin edge
        if (cap_edge && !cap_block_q) begin
            capture_d = count_p2_q + 16'h0001;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_q <= '0;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // No reset: compare, capture and edge select keep their contents
    always_ff @(posedge clk) begin
        compare_q <= compare_d;
        capture_q <= capture_d;
        edge_q    <= edge_d;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign rdata              = rdata_q;
    assign pin_drive           = compare_pin_direction_bit && matched_q;
    assign compare_output_en_n = !pin_drive;
    assign compare_output_pin  = pin_drive && level_q;
    assign timer_irq = (ovf_flag_q && ctrl_q.ovf_ie)
                     || (cmp_flag_q && ctrl_q.cmp_ie)
                     || (cap_flag_q && ctrl_q.cap_ie);
endmodule

// >>> include/frt_pkg.sv
/*
 * Constants and carriers for the free-running timer with capture and compare.
 * Assumes a byte-wide CPU register port with 8-bit register addresses.
 */
package frt_pkg;
    // ------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL     = 8'h12;
    localparam logic [7:0] ADDR_FLAGS    = 8'h13;
    localparam logic [7:0] ADDR_CAP_HI   = 8'h14;
    localparam logic [7:0] ADDR_CAP_LO   = 8'h15;
    localparam logic [7:0] ADDR_CMP_HI   = 8'h16;
    localparam logic [7:0] ADDR_CMP_LO   = 8'h17;
    localparam logic [7:0] ADDR_CNT_HI   = 8'h18;
    localparam logic [7:0] ADDR_CNT_LO   = 8'h19;
    localparam logic [7:0] ADDR_ALT_HI   = 8'h1A;
    localparam logic [7:0] ADDR_ALT_LO   = 8'h1B;

    // ------------------------------------------------------------
    // Field positions in control and flag registers
    // ------------------------------------------------------------
    localparam int CTRL_CAP_IE  = 7;
    localparam int CTRL_CMP_IE  = 6;
    localparam int CTRL_OVF_IE  = 5;
    localparam int CTRL_EDGE    = 1;
    localparam int CTRL_LEVEL   = 0;
    localparam int FLAG_CAP     = 7;
    localparam int FLAG_CMP     = 6;
    localparam int FLAG_OVF     = 5;

    // ------------------------------------------------------------
    // Reset values and timing
    // ------------------------------------------------------------
    localparam logic [15:0] CNT_RESET = 16'hFFFC;
    localparam logic [15:0] CNT_MAX   = 16'hFFFF;
    localparam int          PRESCALE  = 4;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } frt_bus_req_t;

    typedef struct packed {
        logic cap_ie;
        logic cmp_ie;
        logic ovf_ie;
        logic edge_rise;
        logic level;
    } frt_ctrl_t;

    typedef enum logic [2:0] {
        RD_IDLE = 3'b001,
        RD_CNT  = 3'b010,
        RD_CAP  = 3'b100
    } frt_hold_t;
endpackage

// >>> logic/frt_prescale.sv
/*
 * Fixed divider producing a one-cycle enable every DIV clocks.
 * Assumes run is a level on the same clock.
 */
`timescale 1ns/1ps
module frt_prescale #(
    parameter int DIV = frt_pkg::PRESCALE
) (
    input  wire logic clk,   // System clock
    input  wire logic rst,   // Async reset, high
    input  wire logic run,   // Divider enable
    output logic      tick   // One-cycle enable
);
    localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [W-1:0] LAST = W'(DIV - 1);

    logic [W-1:0] div_q;
    logic [W-1:0] div_d;

    always_comb begin
        div_d = div_q;
        if (run) begin
            div_d = (div_q == LAST) ? '0 : div_q + W'(1);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_q <= '0;
        end else begin
            div_q <= div_d;
        end
    end

    assign tick = run && (div_q == LAST);
endmodule

// >>> logic/frt_edge_sync.sv
/*
 * Two-flop synchroniser and edge detector for the capture pin.
 * Assumes pin is asynchronous to clk; polarity comes from clk logic.
 */
`timescale 1ns/1ps
module frt_edge_sync (
    input  wire logic clk,        // System clock
    input  wire logic rst,        // Async reset, high
    input  wire logic pin,        // Raw capture pin
    input  wire logic rise_sel,   // 1 rising, 0 falling
    output logic      edge_seen   // One-cycle pulse on selected edge
);
    logic meta_q;
    logic sync_q;
    logic prev_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            meta_q <= pin;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign edge_seen = rise_sel ? (sync_q && !prev_q) : (!sync_q && prev_q);
endmodule

// >>> testbench/frt_timer_asserts.sv
/* Port checker for the capture/compare timer, bound onto frt_timer.
   Assumes a single clock domain and the async active-high reset. */
`timescale 1ns/1ps
module frt_timer_asserts (
    input wire logic                  clk,                       // Clock
    input wire logic                  rst,                       // Reset
    input wire frt_pkg::frt_bus_req_t bus_req,                   // CPU access
    input wire logic [7:0]            rdata,                     // Read byte
    input wire logic                  compare_pin_direction_bit, // Pin dir
    input wire logic                  compare_output_pin,        // Level
    input wire logic                  compare_output_en_n,       // Drive, active low
    input wire logic                  timer_irq                  // Request
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ------------------------------
    // Properties
    // ------------------------------
    property p_dir_gate; !compare_pin_direction_bit |-> compare_output_en_n; endproperty
    a_dir_gate: assert property (p_dir_gate) else $error("pin driven as input");
    property p_pin_idle; compare_output_en_n |-> !compare_output_pin; endproperty
    a_pin_idle: assert property (p_pin_idle) else $error("idle pin not low");
    property p_en_hold;
        !compare_output_en_n && compare_pin_direction_bit |=> !compare_output_en_n
            || !compare_pin_direction_bit;
    endproperty
    a_en_hold: assert property (p_en_hold) else $error("pin drive dropped");
    property p_irq_off;
        bus_req.wr && bus_req.addr == 8'h12 && bus_req.wdata[7:5] == 3'h0 |=> !timer_irq;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("request while disabled");
    property p_cmp_rw;
        (bus_req.wr && bus_req.addr == 8'h16) ##2 (bus_req.rd && bus_req.addr == 8'h16)
            |=> rdata == $past(bus_req.wdata, 3);
    endproperty
    a_cmp_rw: assert property (p_cmp_rw) else $error("compare byte lost");
    property p_ctrl_bits; bus_req.rd && bus_req.addr == 8'h12 |=> rdata[4:2] == 3'h0; endproperty
    a_ctrl_bits: assert property (p_ctrl_bits) else $error("unused bits set");
    property p_flag_bits; bus_req.rd && bus_req.addr == 8'h13 |=> rdata[4:0] == 5'h00; endproperty
    a_flag_bits: assert property (p_flag_bits) else $error("unused flags set");
    property p_rd_hold; !$past(bus_req.rd) |-> $stable(rdata); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read byte moved");
    c_match: cover property ($fell(compare_output_en_n));
    c_irq: cover property ($rose(timer_irq));
    c_cap_hi: cover property (bus_req.rd && bus_req.addr == 8'h14);
endmodule
bind frt_timer frt_timer_asserts u_frt_timer_asserts (
    .clk(clk), .rst(rst), .bus_req(bus_req), .rdata(rdata),
    .compare_pin_direction_bit(compare_pin_direction_bit),
    .compare_output_pin(compare_output_pin), .compare_output_en_n(compare_output_en_n),
    .timer_irq(timer_irq));

// >>> testbench/frt_pin_model.sv
/* Far-side pin model: moves the capture pin on request, watches the pad.
   Assumes go is a one-cycle request from the bench on clk. */
`timescale 1ns/1ps
module frt_pin_model (
    input  wire logic clk,                // Clock
    input  wire logic go,                 // Pin change request
    input  wire logic level,              // New capture level
    input  wire logic slow,               // Late change
    output logic      capture_input_pin,  // Capture pin
    input  wire logic compare_output_pin, // Compare level
    input  wire logic compare_output_en_n, // Pad driven when low
    output logic      pad_level           // Pad as seen
);
    logic [2:0] wait_q = 3'h0;
    logic       lvl_q  = 1'b0;
    logic       last_q = 1'b0;
    initial capture_input_pin = 1'b0;
    // Change lands mid-cycle so the pin is truly unrelated to clk
    always @(posedge clk) begin
        if (go) begin
            wait_q <= slow ? 3'h5 : 3'h1;
            lvl_q  <= level;
        end else if (wait_q == 3'h1) begin
            capture_input_pin <= #1.3 lvl_q;
            wait_q <= 3'h0;
        end else if (wait_q != 3'h0) begin
            wait_q <= wait_q - 3'h1;
        end
        if (!compare_output_en_n) begin
            last_q <= compare_output_pin;
        end
    end
    // No pull on the pad: undriven it shows the opposite of its last level
    assign pad_level = !compare_output_en_n ? compare_output_pin : ~last_q;
endmodule

// >>> testbench/tb_top.sv
/* Self-checking bench: register sequences through the byte strobes.
   Assumes frt_pin_model as far side and the bound port checker. */
`timescale 1ns/1ps
module tb_top;
    logic                  clk, rst, osc_ready, dir_bit, cap_pin, cmp_pin, cmp_en_n, timer_irq;
    logic                  go, go_lvl, go_slow, pad;
    frt_pkg::frt_bus_req_t bus_req;
    logic [7:0]            rdata, b, h;
    logic [15:0]           v, w, t;
    int                    bad_count, check_count, cycles;
    frt_timer u_frt_timer (.clk(clk), .rst(rst), .osc_ready(osc_ready), .bus_req(bus_req),
        .rdata(rdata), .capture_input_pin(cap_pin), .compare_pin_direction_bit(dir_bit),
        .compare_output_pin(cmp_pin), .compare_output_en_n(cmp_en_n), .timer_irq(timer_irq));
    frt_pin_model u_frt_pin_model (.clk(clk), .go(go), .level(go_lvl), .slow(go_slow),
        .capture_input_pin(cap_pin), .compare_output_pin(cmp_pin),
        .compare_output_en_n(cmp_en_n), .pad_level(pad));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            summarize();
        end
    end
    // ------------------------------
    // Bus tasks: each rd, wr or pin call spans two clocks, rd16 four
    // ------------------------------
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        bus_req <= {1'b1, 1'b0, a, 8'h00};
        @(posedge clk);
        bus_req <= '0;
        #1;
        d = rdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_req <= {1'b0, 1'b1, a, d};
        @(posedge clk);
        bus_req <= '0;
        #1;
    endtask
    task automatic rd16(input logic [7:0] a, output logic [15:0] x);
        rd(a, x[15:8]);
        rd(a + 8'h01, x[7:0]);
    endtask
    task automatic pin(input logic l, input logic s);
        @(posedge clk);
        go <= 1'b1;
        go_lvl <= l;
        go_slow <= s;
        @(posedge clk);
        go <= 1'b0;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // ------------------------------
    // Tests; idle counts keep sample points exact multiples of four
    // ------------------------------
    initial begin
        {rst, osc_ready, dir_bit, go, go_lvl, go_slow} = 6'h20;
        bus_req = '0;
        {bad_count, check_count, cycles} = '0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rd16(8'h18, v);
        chk(v, frt_pkg::CNT_RESET);
        rd16(8'h1A, v);
        chk(v, frt_pkg::CNT_RESET);
        rd(8'h30, b);
        chk(16'(b), 16'h0000);
        wr(8'h12, 8'hFF);
        rd(8'h12, b);
        chk(16'(b), 16'h00E3);
        wr(8'h12, 8'h20);
        @(posedge clk) osc_ready <= 1'b1;
        idle(40);
        rd(8'h13, b);
        chk(16'(b & 8'h20), 16'h0020);
        chk(16'(timer_irq), 16'h0001);
        rd16(8'h1A, v);
        rd(8'h13, b);
        chk(16'(b & 8'h20), 16'h0020);
        rd16(8'h18, v);
        rd(8'h13, b);
        chk(16'(b & 8'h20), 16'h0000);
        chk(16'(timer_irq), 16'h0000);
        idle(394);
        rd16(8'h18, w);
        chk(w, v + 16'h0064);
        idle(396);
        rd(8'h1A, b);
        idle(80);
        rd(8'h1A, b);
        rd(8'h1B, b);
        chk(16'(b), (w + 16'h0064) & 16'h00FF);
        idle(314);
        rd(8'h1B, b);
        chk(16'(b), (w + 16'h00C8) & 16'h00FF);
        @(posedge clk) dir_bit <= 1'b1;
        wr(8'h12, 8'h01);
        rd16(8'h1A, v);
        t = v + 16'h0032;
        wr(8'h16, t[15:8]);
        rd(8'h13, b);
        wr(8'h17, t[7:0]);
        idle(300);
        rd(8'h13, b);
        chk(16'(b & 8'h40), 16'h0040);
        chk(16'({!cmp_en_n, cmp_pin, pad}), 16'h0007);
        wr(8'h17, t[7:0]);
        rd(8'h13, b);
        chk(16'(b & 8'h40), 16'h0000);
        wr(8'h12, 8'h00);
        wr(8'h16, t[15:8] + 8'h01);
        rd(8'h16, b);
        chk(16'(b), 16'(t[15:8] + 8'h01));
        rd(8'h17, b);
        chk(16'(b), 16'(t[7:0]));
        idle(1100);
        rd(8'h13, b);
        chk(16'(b & 8'h40), 16'h0000);
        chk(16'(cmp_pin), 16'h0001);
        rd16(8'h1A, v);
        t = v + 16'h0028;
        wr(8'h16, t[15:8]);
        wr(8'h17, t[7:0]);
        wr(8'h17, t[7:0]);
        idle(200);
        rd(8'h13, b);
        chk(16'(b & 8'h40), 16'h0040);
        chk(16'(cmp_pin), 16'h0000);
        wr(8'h12, 8'h02);
        rd16(8'h1A, v);
        pin(1'b1, 1'b0);
        idle(98);
        pin(1'b0, 1'b1);
        rd16(8'h14, t);
        chk(16'(t - v - 16'h0001 < 16'h0003), 16'h0001);
        rd(8'h13, b);
        chk(16'(b & 8'h80), 16'h0080);
        wr(8'h12, 8'h00);
        idle(90);
        pin(1'b1, 1'b1);
        idle(198);
        pin(1'b0, 1'b0);
        idle(20);
        rd(8'h14, h);
        idle(176);
        pin(1'b1, 1'b0);
        idle(198);
        pin(1'b0, 1'b0);
        idle(20);
        rd(8'h15, b);
        chk({h, b}, t + 16'h0064);
        rd16(8'h14, w);
        chk(w, t + 16'h0064);
        idle(172);
        pin(1'b1, 1'b0);
        idle(198);
        pin(1'b0, 1'b0);
        idle(20);
        rd16(8'h14, w);
        chk(w, t + 16'h012C);
        rd(8'h13, b);
        rd(8'h15, b);
        rd(8'h13, b);
        chk(16'(b & 8'h80), 16'h0000);
        // Mid-run reset: counter reloads, capture value survives
        @(posedge clk) rst <= 1'b1;
        idle(2);
        rst <= 1'b0;
        rd16(8'h18, v);
        chk(v, frt_pkg::CNT_RESET);
        rd16(8'h14, v);
        chk(v, w);
        summarize();
    end
endmodule
